//--- pcsd_cfg.svh
// Register indices, reset values, field positions and counts of the PCS
// debug and configuration bank. Included by the bank and its bench.
`ifndef PCSD_CFG_SVH
`define PCSD_CFG_SVH
// -----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------------
`define PCSD_IDX_LMON   12'h559
`define PCSD_IDX_SYMB   12'h55B
`define PCSD_IDX_OAM    12'h55C
`define PCSD_IDX_MEM    12'h561
`define PCSD_IDX_SYNC   12'h573
`define PCSD_IDX_STAT   12'h580
`define PCSD_IDX_ISTAT  12'h581
`define PCSD_IDX_IMASK  12'h582
// -----------------------------------------------------------------------
// Reset values and writable-bit masks
// -----------------------------------------------------------------------
`define PCSD_RST_LMON   16'h0051
`define PCSD_RST_SYMB   16'h0000
`define PCSD_RST_OAM    16'h0000
`define PCSD_RST_MEM    16'h17A0
`define PCSD_RST_SYNC   16'h0000
`define PCSD_RST_IRQ    2'h0
`define PCSD_WM_LMON    16'h007F
`define PCSD_WM_SYMB    16'h001F
`define PCSD_WM_OAM     16'h0003
`define PCSD_WM_MEM     16'h1FFF
`define PCSD_WM_SYNC    16'h01FF
// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define PCSD_LM_FVAL    6
`define PCSD_LM_FEN     5
`define PCSD_LM_STD     4
`define PCSD_SP_AUTO    4
`define PCSD_SP_RXREV   3
`define PCSD_SP_RXINV   2
`define PCSD_SP_TXREV   1
`define PCSD_SP_TXINV   0
`define PCSD_OAM_RX     1
`define PCSD_OAM_TX     0
`define PCSD_TM_WAIT_HI 12
`define PCSD_TM_WAIT_LO 6
`define PCSD_TM_SEL     5
`define PCSD_TM_INF     4
`define PCSD_TM_XCOR    3
`define PCSD_TM_ECC     2
`define PCSD_TM_SIGD    1
`define PCSD_TM_MODE    0
`define PCSD_FS_EN      8
`define PCSD_IRQ_ALARM  0
`define PCSD_IRQ_CAPT   1
// -----------------------------------------------------------------------
// Counts
// -----------------------------------------------------------------------
`define PCSD_WIN_CYCLES 1024
`define PCSD_NSYM       7
`define PCSD_CAP_DW     8
`endif

//--- pcsd_pkg.sv
// Types shared by the PCS debug and configuration bank.
// Assumes nothing of its surroundings.
package pcsd_pkg;
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_WAIT = 3'b010,
    CAP_ARM  = 3'b100
  } pcsd_cap_st_t;

  // Ternary symbol code: 00 zero, 01 plus one, 11 minus one
  typedef logic [1:0] pcsd_sym_t;

  function automatic pcsd_sym_t pcsd_sym_flip(input pcsd_sym_t s);
    return s[0] ? {~s[1], 1'b1} : s;
  endfunction : pcsd_sym_flip
endpackage : pcsd_pkg

//--- pcsd_sym_map.sv
// Polarity and order mapping of one symbol group, registered.
// Assumes a synchronous active-high reset and a clock enable.
module pcsd_sym_map import pcsd_pkg::*; #(
  parameter int NSYM = 7
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              vld_i,
  input  wire logic [2*NSYM-1:0] grp_i,
  input  wire logic              inv_pol_i,
  input  wire logic              rev_i,
  output logic                   vld_o,
  output logic      [2*NSYM-1:0] grp_o
);
  if (NSYM < 1) begin : g_bad_nsym
    $error("NSYM must be at least one");
  end

  logic [2*NSYM-1:0] map_nxt;

  always_comb begin
    map_nxt = '0;
    for (int i = 0; i < NSYM; i++) begin
      pcsd_sym_t s;
      s = rev_i ? grp_i[2*(NSYM-1-i) +: 2] : grp_i[2*i +: 2];
      map_nxt[2*i +: 2] = inv_pol_i ? pcsd_sym_flip(s) : s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vld_o <= 1'b0;
      grp_o <= '0;
    end else if (ce_i) begin
      vld_o <= vld_i;
      grp_o <= map_nxt;
    end
  end

  a_pol_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && inv_pol_i && !rev_i) |=> grp_o[1:0] == pcsd_sym_flip($past(grp_i[1:0])))
    else $error("symbol polarity not inverted");

  a_order_rev: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rev_i && !inv_pol_i) |=> grp_o[1:0] == $past(grp_i[2*NSYM-1 -: 2]))
    else $error("symbol order not reversed");
endmodule : pcsd_sym_map

//--- pcsd_config_bank.sv
// PCS debug and configuration register bank with its datapath hooks.
// Assumes a classic Wishbone master and PCS datapath strobes that are
// synchronous to clk_i; ce_i low freezes every flip-flop.
//
// Contract
// - Override enable drives alarm from override value
// - Standard mode counts only after link up
// - Alarm when any symbol count misses threshold
// - Slave auto fix: tx polarity follows rx
// - Rx order inversion reverses symbol group
// - Rx polarity inversion flips every received symbol
// - Tx order inversion reverses symbol group
// - Tx polarity inversion flips every sent symbol
// - Rx CRC input order from its bit
// - Tx CRC input order from its bit
// - Xcorr capture waits delay, writes on energy fall
// - Selector picks aligned or shifted detector
// - Endless send sequence only master, companion set
// - Xcorr only in send mode, else normal
// - ECC bit steers decoder memory ECC
// - Send mode: transitions or signal-detect capture
// - Mode bit: send info or training info
// - Sync override holds state at value
`include "pcsd_cfg.svh"
module pcsd_config_bank import pcsd_pkg::*; #(
  parameter int WIN_CYCLES = `PCSD_WIN_CYCLES,
  parameter int NSYM       = `PCSD_NSYM,
  parameter int DW         = `PCSD_CAP_DW
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [15:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq_o,
  // Line monitor
  input  wire logic              link_up_i,
  input  wire logic              sym_zero_i,
  input  wire logic              sym_pos_i,
  input  wire logic              sym_neg_i,
  output logic                   line_alarm_o,
  // Symbol paths
  input  wire logic              is_master_i,
  input  wire logic              rx_pol_det_i,
  input  wire logic              tx_vld_i,
  input  wire logic [2*NSYM-1:0] tx_grp_i,
  output logic                   tx_vld_o,
  output logic      [2*NSYM-1:0] tx_grp_o,
  input  wire logic              rx_vld_i,
  input  wire logic [2*NSYM-1:0] rx_grp_i,
  output logic                   rx_vld_o,
  output logic      [2*NSYM-1:0] rx_grp_o,
  // OAM CRC and decoder memory
  output logic                   rx_crc_msb_first_o,
  output logic                   tx_crc_msb_first_o,
  output logic                   rs_mem_ecc_en_o,
  // Debug capture
  input  wire logic              send_seq_ext_en_i,
  input  wire logic              send_seq_tx_i,
  input  wire logic              energy_fall_i,
  input  wire logic              state_chg_i,
  input  wire logic              sigdet_i,
  input  wire logic [DW-1:0]     send_info_i,
  input  wire logic [DW-1:0]     xcorr_align_i,
  input  wire logic [DW-1:0]     xcorr_shift_i,
  input  wire logic              train_vld_i,
  input  wire logic [DW-1:0]     train_info_i,
  output logic                   cap_we_o,
  output logic      [DW-1:0]     cap_dat_o,
  output logic                   send_seq_endless_o,
  // Link sync override
  output logic                   sync_force_en_o,
  output logic      [7:0]        sync_force_val_o
);
  if (WIN_CYCLES < 16 || WIN_CYCLES > 65536) begin : g_bad_win
    $error("WIN_CYCLES must lie in 16..65536");
  end
  if (DW < 1 || DW > 16) begin : g_bad_dw
    $error("DW must lie in 1..16");
  end

  localparam logic [15:0] WIN_END = 16'(WIN_CYCLES - 1);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [15:0] d,
                                         input logic [1:0]  sel,
                                         input logic [15:0] wm);
    logic [15:0] m;
    m = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    return m & wm;
  endfunction : wmerge

  function automatic logic [3:0] sat_inc(input logic [3:0] c, input logic hit);
    return (hit && c != 4'hF) ? 4'(c + 4'h1) : c;
  endfunction : sat_inc

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic         ack_r;
  logic [31:0]  dat_r;
  logic [15:0]  lmon_r;
  logic [15:0]  symb_r;
  logic [15:0]  oam_r;
  logic [15:0]  mem_r;
  logic [15:0]  sync_r;
  logic [1:0]   istat_r;
  logic [1:0]   imask_r;
  logic         irq_r;
  logic         run_r;
  logic [15:0]  win_r;
  logic [3:0]   cz_r;
  logic [3:0]   cp_r;
  logic [3:0]   cn_r;
  logic         araw_r;
  logic         alarm_r;
  pcsd_cap_st_t cap_st_r;
  logic [6:0]   dly_r;
  logic         send_d_r;
  logic         sig_d_r;
  logic         cap_we_r;
  logic [DW-1:0] cap_dat_r;
  logic         endless_r;

  logic [11:0]  idx;
  logic         req;
  logic         wr;
  logic [15:0]  rd_nxt;
  logic [3:0]   th;
  logic         fval;
  logic         alarm_nxt;
  logic         xc_act;
  logic         xsel;
  logic [6:0]   wait_f;
  logic         tx_inv;
  logic         cap_we_nxt;
  logic [DW-1:0] cap_dat_nxt;
  logic [1:0]   ev;
  logic [1:0]   clr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // -----------------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------------
  // Answer one cycle after the strobe; unmapped indices read zero.
  assign idx = wb_adr_i[13:2];
  assign req = ce_i && wb_cyc_i && wb_stb_i && !ack_r;
  assign wr  = req && wb_we_i;

  always_comb begin
    unique case (idx)
      `PCSD_IDX_LMON:  rd_nxt = lmon_r;
      `PCSD_IDX_SYMB:  rd_nxt = symb_r;
      `PCSD_IDX_OAM:   rd_nxt = oam_r;
      `PCSD_IDX_MEM:   rd_nxt = mem_r;
      `PCSD_IDX_SYNC:  rd_nxt = sync_r;
      `PCSD_IDX_STAT:  rd_nxt = {11'h000, cap_st_r, run_r, araw_r};
      `PCSD_IDX_ISTAT: rd_nxt = {14'h0000, istat_r};
      `PCSD_IDX_IMASK: rd_nxt = {14'h0000, imask_r};
      default:         rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= req;
      dat_r <= (req && !wb_we_i) ? {16'h0000, rd_nxt} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lmon_r  <= `PCSD_RST_LMON;
      symb_r  <= `PCSD_RST_SYMB;
      oam_r   <= `PCSD_RST_OAM;
      mem_r   <= `PCSD_RST_MEM;
      sync_r  <= `PCSD_RST_SYNC;
      imask_r <= `PCSD_RST_IRQ;
    end else if (wr) begin
      // Write masks keep reserved bits at zero
      if (idx == `PCSD_IDX_LMON)
        lmon_r <= wmerge(lmon_r, wb_dat_i[15:0], wb_sel_i[1:0], `PCSD_WM_LMON);
      if (idx == `PCSD_IDX_SYMB)
        symb_r <= wmerge(symb_r, wb_dat_i[15:0], wb_sel_i[1:0], `PCSD_WM_SYMB);
      if (idx == `PCSD_IDX_OAM)
        oam_r <= wmerge(oam_r, wb_dat_i[15:0], wb_sel_i[1:0], `PCSD_WM_OAM);
      if (idx == `PCSD_IDX_MEM)
        mem_r <= wmerge(mem_r, wb_dat_i[15:0], wb_sel_i[1:0], `PCSD_WM_MEM);
      if (idx == `PCSD_IDX_SYNC)
        sync_r <= wmerge(sync_r, wb_dat_i[15:0], wb_sel_i[1:0], `PCSD_WM_SYNC);
      if (idx == `PCSD_IDX_IMASK && wb_sel_i[0])
        imask_r <= wb_dat_i[1:0];
    end
  end

  a_reserved_zero: assert property (
    (lmon_r & ~`PCSD_WM_LMON) == 16'h0000 && (symb_r & ~`PCSD_WM_SYMB) == 16'h0000
    && (mem_r & ~`PCSD_WM_MEM) == 16'h0000 && wb_dat_o[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  // Plain register fields
  assign rx_crc_msb_first_o = oam_r[`PCSD_OAM_RX];
  assign tx_crc_msb_first_o = oam_r[`PCSD_OAM_TX];
  assign rs_mem_ecc_en_o    = mem_r[`PCSD_TM_ECC];
  assign sync_force_en_o    = sync_r[`PCSD_FS_EN];
  assign sync_force_val_o   = sync_r[7:0];

  // -----------------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------------
  // A set in the clearing cycle wins; irq follows status one cycle late.
  assign clr = (wr && idx == `PCSD_IDX_ISTAT && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
  assign ev  = {ce_i && cap_we_nxt, ce_i && alarm_nxt && !alarm_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_r <= `PCSD_RST_IRQ;
    end else if (ce_i) begin
      istat_r <= (istat_r & ~clr) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  assign irq_o = irq_r;

  a_set_wins: assert property (
    (ce_i && ev[`PCSD_IRQ_ALARM]) |=> istat_r[`PCSD_IRQ_ALARM])
    else $error("alarm event lost");

  // -----------------------------------------------------------------------
  // Line monitor
  // -----------------------------------------------------------------------
  assign th   = lmon_r[3:0];
  assign fval = lmon_r[`PCSD_LM_FVAL];

  // With standard mode off the counters run regardless of link state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else if (ce_i) begin
      run_r <= !lmon_r[`PCSD_LM_STD] || link_up_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_r  <= 16'h0000;
      cz_r   <= 4'h0;
      cp_r   <= 4'h0;
      cn_r   <= 4'h0;
      araw_r <= 1'b0;
    end else if (ce_i) begin
      if (!run_r) begin
        win_r  <= 16'h0000;
        cz_r   <= 4'h0;
        cp_r   <= 4'h0;
        cn_r   <= 4'h0;
        araw_r <= 1'b0;
      end else if (win_r == WIN_END) begin
        win_r  <= 16'h0000;
        cz_r   <= 4'h0;
        cp_r   <= 4'h0;
        cn_r   <= 4'h0;
        araw_r <= (cz_r < th) || (cp_r < th) || (cn_r < th);
      end else begin
        win_r <= 16'(win_r + 16'h0001);
        cz_r  <= sat_inc(cz_r, sym_zero_i);
        cp_r  <= sat_inc(cp_r, sym_pos_i);
        cn_r  <= sat_inc(cn_r, sym_neg_i);
      end
    end
  end

  assign alarm_nxt = lmon_r[`PCSD_LM_FEN] ? fval : araw_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r <= 1'b0;
    end else if (ce_i) begin
      alarm_r <= alarm_nxt;
    end
  end

  assign line_alarm_o = alarm_r;

  a_force_alarm: assert property (
    (ce_i && lmon_r[`PCSD_LM_FEN]) |=> line_alarm_o == $past(fval))
    else $error("alarm not forced");

  a_mon_wait_link: assert property (
    (ce_i && lmon_r[`PCSD_LM_STD] && !link_up_i) |=> !run_r ##1 (!ce_i || cz_r == 4'h0))
    else $error("monitor ran before link up");

  a_alarm_window: assert property (
    (ce_i && run_r && win_r == WIN_END && cz_r < th) |=> araw_r)
    else $error("alarm missed short count");

  // -----------------------------------------------------------------------
  // Symbol paths
  // -----------------------------------------------------------------------
  assign tx_inv = (symb_r[`PCSD_SP_AUTO] && !is_master_i) ? rx_pol_det_i
                                                          : symb_r[`PCSD_SP_TXINV];

  pcsd_sym_map #(.NSYM(NSYM)) u_tx_map (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .vld_i     (tx_vld_i),
    .grp_i     (tx_grp_i),
    .inv_pol_i (tx_inv),
    .rev_i     (symb_r[`PCSD_SP_TXREV]),
    .vld_o     (tx_vld_o),
    .grp_o     (tx_grp_o)
  );

  pcsd_sym_map #(.NSYM(NSYM)) u_rx_map (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .vld_i     (rx_vld_i),
    .grp_i     (rx_grp_i),
    .inv_pol_i (symb_r[`PCSD_SP_RXINV]),
    .rev_i     (symb_r[`PCSD_SP_RXREV]),
    .vld_o     (rx_vld_o),
    .grp_o     (rx_grp_o)
  );

  a_follow_pol: assert property (
    (ce_i && symb_r[`PCSD_SP_AUTO] && !is_master_i && tx_grp_i[1:0] == 2'b01
     && !symb_r[`PCSD_SP_TXREV])
    |=> tx_grp_o[1:0] == ($past(rx_pol_det_i) ? 2'b11 : 2'b01))
    else $error("tx polarity did not follow rx");

  // -----------------------------------------------------------------------
  // Debug capture
  // -----------------------------------------------------------------------
  assign xc_act = !mem_r[`PCSD_TM_MODE] && mem_r[`PCSD_TM_XCOR];
  assign xsel   = mem_r[`PCSD_TM_SEL];
  assign wait_f = mem_r[`PCSD_TM_WAIT_HI:`PCSD_TM_WAIT_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      send_d_r <= 1'b0;
      sig_d_r  <= 1'b0;
    end else if (ce_i) begin
      send_d_r <= send_seq_tx_i;
      sig_d_r  <= sigdet_i;
    end
  end

  // Delay counts clock cycles from entry into the send state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_st_r <= CAP_IDLE;
      dly_r    <= 7'h00;
    end else if (ce_i) begin
      if (!xc_act) begin
        cap_st_r <= CAP_IDLE;
      end else begin
        unique case (cap_st_r)
          CAP_IDLE: begin
            dly_r <= 7'h00;
            if (send_seq_tx_i && !send_d_r) cap_st_r <= CAP_WAIT;
          end
          CAP_WAIT: begin
            if (dly_r == wait_f) cap_st_r <= CAP_ARM;
            else dly_r <= 7'(dly_r + 7'h01);
          end
          CAP_ARM: begin
            if (energy_fall_i) cap_st_r <= CAP_IDLE;
          end
          default: cap_st_r <= CAP_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    cap_we_nxt  = 1'b0;
    cap_dat_nxt = send_info_i;
    if (mem_r[`PCSD_TM_MODE]) begin
      cap_we_nxt  = train_vld_i;
      cap_dat_nxt = train_info_i;
    end else if (xc_act) begin
      cap_we_nxt  = (cap_st_r == CAP_ARM) && energy_fall_i;
      cap_dat_nxt = xsel ? xcorr_shift_i : xcorr_align_i;
    end else if (mem_r[`PCSD_TM_SIGD]) begin
      cap_we_nxt  = sigdet_i != sig_d_r;
    end else begin
      cap_we_nxt  = state_chg_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_we_r  <= 1'b0;
      cap_dat_r <= '0;
    end else if (ce_i) begin
      cap_we_r  <= cap_we_nxt;
      cap_dat_r <= cap_dat_nxt;
    end
  end

  assign cap_we_o  = cap_we_r;
  assign cap_dat_o = cap_dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endless_r <= 1'b0;
    end else if (ce_i) begin
      endless_r <= mem_r[`PCSD_TM_INF] && is_master_i && send_seq_ext_en_i;
    end
  end

  assign send_seq_endless_o = endless_r;

  sequence s_enter_wait;
    ce_i && xc_act && cap_st_r == CAP_IDLE && send_seq_tx_i && !send_d_r;
  endsequence

  sequence s_wait_done;
    ce_i && xc_act && cap_st_r == CAP_WAIT && dly_r == wait_f;
  endsequence

  a_xcorr_start: assert property (
    s_enter_wait |=> cap_st_r == CAP_WAIT && dly_r == 7'h00)
    else $error("xcorr wait not started");

  a_xcorr_arm: assert property (
    s_wait_done |=> cap_st_r == CAP_ARM)
    else $error("xcorr not armed after delay");

  a_xcorr_quiet: assert property (
    (ce_i && xc_act && cap_st_r != CAP_ARM) |=> !cap_we_o)
    else $error("xcorr wrote outside armed state");

  a_xcorr_sel: assert property (
    (ce_i && xc_act && cap_st_r == CAP_ARM && energy_fall_i)
    |=> cap_we_o && cap_dat_o == ($past(xsel) ? $past(xcorr_shift_i)
                                              : $past(xcorr_align_i)))
    else $error("wrong detector captured");

  a_train_cap: assert property (
    (ce_i && mem_r[`PCSD_TM_MODE] && train_vld_i)
    |=> cap_we_o && cap_dat_o == $past(train_info_i))
    else $error("training info not captured");

  a_endless_gate: assert property (
    (ce_i && !is_master_i) |=> !send_seq_endless_o)
    else $error("endless send outside master");
endmodule : pcsd_config_bank

//--- pcsd_link_model.sv
// Link partner model: legal ternary symbol groups every cycle, a polarity
// flag, and one symbol pulse per cycle, zero, plus, minus in turn.
// Assumes the bench seeds the generator; no reset needed.
module pcsd_link_model (
  input  wire logic        clk_i,
  output logic             vld_o,
  output logic [13:0]      grp_o,
  output logic             pol_o,
  output logic [2:0]       sym_o
);
  initial begin
    vld_o = 1'b1;
    grp_o = 14'h0;
    pol_o = 1'b0;
    sym_o = 3'h1;
  end
  always @(posedge clk_i) begin
    for (int i = 0; i < 7; i++) grp_o[2*i +: 2] <= 2'(6'h34 >> (2 * ($urandom % 3)));
    pol_o <= 1'($urandom);
    sym_o <= {sym_o[1:0], sym_o[2]};
  end
endmodule : pcsd_link_model

//--- tb_top.sv
// Self-checking bench for the PCS configuration bank.
// Assumes the link model drives the receive side and symbol pulses.
`include "pcsd_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lnk = 0;
  logic        mst = 0, ext = 0, stc = 0, trn = 0, chk_en = 0, cap_en = 0;
  logic        sgd = 0, sgp = 0, sst = 0, ssp = 0, efl = 0;
  logic [3:0]  sel = 4'h0;
  logic [15:0] adr = 16'h0, q;
  logic [31:0] dat = 32'h0, rd;
  logic [13:0] txg = 14'h0, etx, erx, txo, rxo, rxg;
  logic [7:0]  inf = 8'h0, tin = 8'h0, ed, cd, sv;
  logic        ack, irq, alm, txv, rxv, rxvi, pol, ew, cw, rc, tc, ecc, eo, se;
  logic [2:0]  sym;
  int          error_cnt = 0, num_checks = 0, cycles = 0;
  int          xs = 0, xd = 0; // Capture model: 0 idle, 1 wait, 2 armed
  logic [11:0] idx[5] = '{12'h559, 12'h55B, 12'h55C, 12'h561, 12'h573};
  logic [15:0] rv[5] = '{16'h51, 16'h0, 16'h0, 16'h17A0, 16'h0};
  logic [15:0] wm[5] = '{16'h7F, 16'h1F, 16'h3, 16'h1FFF, 16'h1FF};
  logic [15:0] lm[5] = '{16'h16, 16'h16, 16'h15, 16'h75, 16'h36};
  logic [15:0] sh[5];
  logic [4:0]  lk = 5'b11110, la = 5'b01010;
  logic [15:0] cm[6] = '{16'h17A1, 16'h17A9, 16'h17A2, 16'h00E8, 16'h00C8, 16'h17A0};

  pcsd_config_bank #(.WIN_CYCLES(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .irq_o(irq), .link_up_i(lnk), .sym_zero_i(sym[0]),
    .sym_pos_i(sym[1]), .sym_neg_i(sym[2]), .line_alarm_o(alm), .is_master_i(mst),
    .rx_pol_det_i(pol), .tx_vld_i(1'b1), .tx_grp_i(txg), .tx_vld_o(txv),
    .tx_grp_o(txo), .rx_vld_i(rxvi), .rx_grp_i(rxg), .rx_vld_o(rxv), .rx_grp_o(rxo),
    .rx_crc_msb_first_o(rc), .tx_crc_msb_first_o(tc), .rs_mem_ecc_en_o(ecc),
    .send_seq_ext_en_i(ext), .send_seq_tx_i(sst), .energy_fall_i(efl),
    .state_chg_i(stc), .sigdet_i(sgd), .send_info_i(inf), .xcorr_align_i(inf),
    .xcorr_shift_i(tin), .train_vld_i(trn), .train_info_i(tin), .cap_we_o(cw),
    .cap_dat_o(cd), .send_seq_endless_o(eo), .sync_force_en_o(se),
    .sync_force_val_o(sv));
  pcsd_link_model lp (.clk_i(clk_i), .vld_o(rxvi), .grp_o(rxg), .pol_o(pol), .sym_o(sym));

  always #4 clk_i = ~clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Holds the request until ack is sampled; only the global timeout ends a hang
  task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    int n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, 2'h0, a, 2'h0, 16'h0, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    chk("ack wait", 2, n);
    q = rd[15:0];
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic wr(input int k, input logic [15:0] d, input logic [3:0] s = 4'h3);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & wm[k];
    wb(1'b1, idx[k], d, s);
    sh[k] = (sh[k] & ~m) | (d & m);
  endtask : wr

  function automatic logic [13:0] mapg(logic [13:0] g, logic rev, logic inv);
    logic [13:0] r;
    for (int i = 0; i < 7; i++) begin
      r[2*i +: 2] = g[(rev ? 6 - i : i) * 2 +: 2];
      if (inv && r[2*i]) r[2*i+1] = ~r[2*i+1];
    end
    return r;
  endfunction : mapg

  always @(posedge clk_i) begin
    if (++cycles > 4000) begin
      error_cnt++;
      results();
    end
  end

  always @(posedge clk_i) begin
    if (chk_en) chk("tx group", {1'b1, etx}, {txv, txo});
    if (chk_en) chk("rx group", {1'b1, erx}, {rxv, rxo});
    if (cap_en) chk("capture", {ew, ed}, {cw, cd & {8{cw}}});
    etx = mapg(txg, sh[1][1], (sh[1][4] && !mst) ? pol : sh[1][0]);
    erx = mapg(rxg, sh[1][3], sh[1][2]);
    ew = sh[3][0] ? trn : sh[3][3] ? (xs == 2 && efl) : sh[3][1] ? sgd != sgp : stc;
    ed = !ew ? 8'h00 : (sh[3][0] || (sh[3][3] && sh[3][5])) ? tin : inf;
    // Xcorr wait lasts delay+1 cycles after a rising send state
    if (sh[3][0] || !sh[3][3]) xs = 0;
    else if (xs == 0) begin
      xd = 0;
      xs = (sst && !ssp) ? 1 : 0;
    end else if (xs == 1) begin
      if (xd == sh[3][12:6]) xs = 2;
      else xd++;
    end else if (efl) xs = 0;
    sgp = sgd;
    ssp = sst;
    for (int i = 0; i < 7; i++) txg[2*i +: 2] <= 2'(6'h34 >> (2 * ($urandom % 3)));
    inf <= 8'($urandom);
    tin <= 8'($urandom);
    trn <= cap_en & 1'($urandom);
    stc <= cap_en & 1'($urandom);
    sgd <= cap_en & 1'($urandom);
    sst <= cap_en & 1'($urandom);
    efl <= cap_en & 1'($urandom);
  end

  initial begin
    void'($urandom(32'hB3CD));
    sh = rv;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      wb(1'b0, idx[k], 16'h0, 4'h3);
      chk("reset value", rv[k], q);
      wr(k, 16'($urandom), 4'($urandom));
      wb(1'b0, idx[k], 16'h0, 4'h3);
      chk("read back", sh[k], q);
    end
    wb(1'b0, 12'h7FF, 16'h0, 4'h3);
    chk("unmapped", 0, q);
    $display("test registers done");
    for (int c = 0; c < 32; c++) begin
      chk_en <= 1'b0;
      mst <= 1'($urandom);
      wr(1, 16'(c));
      repeat (2) @(posedge clk_i);
      chk_en <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
    chk_en <= 1'b0;
    $display("test symbol mapping done");
    for (int j = 0; j < 2; j++) begin
      mst <= 1'b1;
      ext <= j[0];
      wr(2, {14'h0, j[0], j[0]});
      wr(3, j ? 16'h17B4 : 16'h17A0);
      wr(4, j ? 16'h1A5 : 16'h0);
      repeat (3) @(posedge clk_i);
      chk("exports", {{5{j[0]}}, j ? 8'hA5 : 8'h0}, {rc, tc, ecc, eo, se, sv});
    end
    $display("test exports done");
    for (int i = 0; i < 5; i++) begin
      lnk <= lk[i];
      wr(0, lm[i]);
      repeat (40) @(posedge clk_i);
      chk("line alarm", la[i], alm);
    end
    $display("test line monitor done");
    for (int i = 0; i < 6; i++) begin
      cap_en <= 1'b0;
      wr(3, cm[i]);
      repeat (2) @(posedge clk_i);
      cap_en <= 1'b1;
      repeat (30) @(posedge clk_i);
    end
    cap_en <= 1'b0;
    wb(1'b0, 12'h581, 16'h0, 4'h3);
    chk("capture status", 2, q & 16'h2);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 0, irq);
    wb(1'b1, 12'h582, 16'h2, 4'h3);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 1, irq);
    wb(1'b1, 12'h581, 16'h2, 4'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 0, irq);
    $display("test capture and interrupt done");
    results();
  end
endmodule : tb_top
